// file: hw/ssd_params.svh
`ifndef SSD_PARAMS_SVH
`define SSD_PARAMS_SVH

// ----------------------------------------
// Register indices, byte address is index * 4
// ----------------------------------------
`define SSD_IDX_STRAP 8'hb8
`define SSD_IDX_PULLDN 8'hbe
`define SSD_IDX_DEBUG 8'hd0
`define SSD_IDX_IEHI 8'hd8
`define SSD_IDX_NONE 8'hff

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define SSD_ST_INDEX_STRAP_DECODE_DONE 7
`define SSD_ST_IDX_LSB 4
`define SSD_ST_CFG_DONE 3
`define SSD_ST_CFG_LSB 0
`define SSD_DBG_SELFTEST 5
`define SSD_DBG_CONT 1
`define SSD_DBG_SINGLE 0
`define SSD_DBG_RW_MASK 8'hdf
`define SSD_IEHI_MASK 8'h03

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SSD_PULLDN_RST 8'h00
`define SSD_DEBUG_RST 8'h00
`define SSD_IEHI_RST 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSD_CLK_PERIOD_NS 4
`define SSD_STRAP_SETTLE_NS 1000
`define SSD_STRAP_SETTLE_CYC \
  ((`SSD_STRAP_SETTLE_NS + `SSD_CLK_PERIOD_NS - 1) / `SSD_CLK_PERIOD_NS)
`endif

// file: hw/ssd_pkg.sv
package ssd_pkg;
  typedef struct packed {
    logic done;
    logic [2:0] value;
  } ssd_strap_t;

  typedef struct packed {
    logic [2:0] out_mode;
    logic [2:0] in_only;
  } ssd_pin_mode_t;

  typedef enum logic {
    SSD_SETTLE = 1'b0,
    SSD_LATCHED = 1'b1
  } ssd_strap_state_t;
endpackage

// file: hw/ssd_strap_decode.sv
`timescale 1ns/10ps
`include "ssd_params.svh"
module ssd_strap_decode (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Level code from the strap comparator
  input wire logic [2:0] strap_level,
  // Latched decode
  output ssd_pkg::ssd_strap_t strap
);
  import ssd_pkg::*;

  localparam logic [7:0] SETTLE_CYC = 8'(`SSD_STRAP_SETTLE_CYC);

  ssd_strap_state_t state;
  logic [7:0] settle_cnt;
  wire settled = (settle_cnt == SETTLE_CYC - 8'h01);

  // Wait for the strap level to settle, then latch once
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SSD_SETTLE;
      settle_cnt <= 8'h00;
      strap <= '0;
    end else begin
      unique case (state)
        SSD_SETTLE: begin
          settle_cnt <= settle_cnt + 8'h01;
          if (settled) begin
            state <= SSD_LATCHED;
            strap <= '{done: 1'b1, value: strap_level};
          end
        end
        SSD_LATCHED: begin
          settle_cnt <= settle_cnt;
        end
      endcase
    end
  end

  done_latch_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(strap.done) |-> strap.value == $past(strap_level) && $past(settled))
    else $error("strap done without matching latch");

  done_hold_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    strap.done |=> strap.done && $stable(strap.value))
    else $error("latched strap changed after done");
endmodule

// file: hw/ssd_err_inject.sv
`timescale 1ns/10ps
module ssd_err_inject (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Controls
  input wire logic cont_en,
  input wire logic single_pend,
  // Return-channel framer
  input wire logic frame_start,
  output logic frame_corrupt,
  output logic single_done
);
  wire hit_frame = frame_start & (cont_en | single_pend);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_corrupt <= 1'b0;
      single_done <= 1'b0;
    end else begin
      frame_corrupt <= hit_frame;
      single_done <= frame_start & single_pend;
    end
  end

  cont_corrupt_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    cont_en && frame_start |=> frame_corrupt)
    else $error("continuous mode missed a frame");

  single_pair_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    single_done |-> frame_corrupt && $past(frame_start))
    else $error("single done without corrupted frame");
endmodule

// file: hw/ssd_regs.sv
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
`include "ssd_params.svh"
module ssd_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Strap comparator levels
  input wire logic [2:0] idx_strap_level,
  input wire logic [2:0] cfg_strap_level,
  // Pin pulldowns
  input wire ssd_pkg::ssd_pin_mode_t pin_mode,
  output logic [2:0] pd_enable,
  // Return channel
  input wire logic remote_selftest_in,
  input wire logic return_frame_start,
  output logic return_frame_corrupt
);
  import ssd_pkg::*;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    if (addr[31:10] == 22'h0 && addr[1:0] == 2'b00) begin
      return addr[9:2];
    end
    return `SSD_IDX_NONE;
  endfunction

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
    return idx == reg_idx;
  endfunction

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] pulldown_control;
  logic [7:0] port_debug_control;
  logic [7:0] port_interrupt_enable_high;
  logic remote_selftest_active;
  logic wr_pend;
  logic [7:0] wr_idx;
  ssd_strap_t idx_strap;
  ssd_strap_t cfg_strap;
  logic single_done;

  // ----------------------------------------
  // Strap decoders
  // ----------------------------------------
  ssd_strap_decode u_idx_strap (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .strap_level(idx_strap_level),
    .strap(idx_strap)
  );

  ssd_strap_decode u_cfg_strap (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .strap_level(cfg_strap_level),
    .strap(cfg_strap)
  );

  // Status is built only from decoder state, so bus writes cannot touch it
  wire [7:0] strap_decode_status = {idx_strap.done, idx_strap.value,
                                    cfg_strap.done, cfg_strap.value};

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire addr_valid = hsel & htrans[1] & hready;
  wire [7:0] rd_idx = reg_index(haddr);
  wire rd_take = addr_valid & ~hwrite;
  wire rd_strap = hit(rd_idx, `SSD_IDX_STRAP);
  wire rd_pull = hit(rd_idx, `SSD_IDX_PULLDN);
  wire rd_dbg = hit(rd_idx, `SSD_IDX_DEBUG);
  wire rd_iehi = hit(rd_idx, `SSD_IDX_IEHI);
  wire [7:0] wr_byte = hwdata[7:0];
  wire wr_pull = wr_pend & hit(wr_idx, `SSD_IDX_PULLDN);
  wire wr_dbg = wr_pend & hit(wr_idx, `SSD_IDX_DEBUG);
  wire wr_iehi = wr_pend & hit(wr_idx, `SSD_IDX_IEHI);

  // ----------------------------------------
  // Next register values
  // ----------------------------------------
  wire [7:0] next_pulldown = wr_pull ? wr_byte : pulldown_control;
  // Self-test bit is never stored, writes to it fall away
  wire [7:0] dbg_written = wr_dbg ? (wr_byte & `SSD_DBG_RW_MASK)
                                  : port_debug_control;
  // A write of one wins over the self-clear in the same cycle
  wire next_single = wr_dbg ? wr_byte[`SSD_DBG_SINGLE]
                            : port_debug_control[`SSD_DBG_SINGLE] & ~single_done;
  wire [7:0] next_debug = {dbg_written[7:1], next_single};
  wire [7:0] next_iehi = wr_iehi ? (wr_byte & `SSD_IEHI_MASK)
                                 : port_interrupt_enable_high;
  wire [7:0] selftest_field = 8'(remote_selftest_active) << `SSD_DBG_SELFTEST;

  // Pulldown on unless driving, or input-only with the disable bit
  wire [2:0] next_pd_enable = ~pin_mode.out_mode
                            & ~(pulldown_control[2:0] & pin_mode.in_only);

  // ----------------------------------------
  // Read mux, sees a write that lands in this same cycle
  // ----------------------------------------
  wire [7:0] next_rd_byte =
    rd_strap ? strap_decode_status :
    rd_pull ? next_pulldown :
    rd_dbg ? (next_debug | selftest_field) :
    rd_iehi ? next_iehi : 8'h00;

  // ----------------------------------------
  // Bus phase tracking, zero wait states
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend <= 1'b0;
      wr_idx <= `SSD_IDX_NONE;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_valid & hwrite;
      if (addr_valid) begin
        wr_idx <= rd_idx;
      end
      if (rd_take) begin
        hrdata <= {24'h0, next_rd_byte};
      end
    end
  end

  // ----------------------------------------
  // Registers and pins
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulldown_control <= `SSD_PULLDN_RST;
      port_debug_control <= `SSD_DEBUG_RST;
      port_interrupt_enable_high <= `SSD_IEHI_RST;
      remote_selftest_active <= 1'b0;
      pd_enable <= 3'h0;
    end else begin
      pulldown_control <= next_pulldown;
      port_debug_control <= next_debug;
      port_interrupt_enable_high <= next_iehi;
      remote_selftest_active <= remote_selftest_in;
      pd_enable <= next_pd_enable;
    end
  end

  // ----------------------------------------
  // Return-channel error injection
  // ----------------------------------------
  ssd_err_inject u_inject (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .cont_en(port_debug_control[`SSD_DBG_CONT]),
    .single_pend(port_debug_control[`SSD_DBG_SINGLE]),
    .frame_start(return_frame_start),
    .frame_corrupt(return_frame_corrupt),
    .single_done(single_done)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  index_strap_decode_done_read_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    addr_valid && !hwrite && rd_idx == `SSD_IDX_STRAP
    |=> hrdata[`SSD_ST_INDEX_STRAP_DECODE_DONE] == $past(idx_strap.done))
    else $error("index done bit read wrong");

  idx_value_read_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    addr_valid && !hwrite && rd_idx == `SSD_IDX_STRAP
    |=> hrdata[6:4] == $past(idx_strap.value))
    else $error("index strap value read wrong");

  cfg_done_read_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    addr_valid && !hwrite && rd_idx == `SSD_IDX_STRAP
    |=> hrdata[`SSD_ST_CFG_DONE] == $past(cfg_strap.done))
    else $error("config done bit read wrong");

  cfg_value_read_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    addr_valid && !hwrite && rd_idx == `SSD_IDX_STRAP
    |=> hrdata[2:0] == $past(cfg_strap.value))
    else $error("config strap value read wrong");

  pulldown_auto_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    arst_n && !pin_mode.out_mode[0] && !pulldown_control[0] |=> pd_enable[0])
    else $error("pulldown not enabled on input pin");

  pulldown_off_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (pin_mode.in_only[1] && pulldown_control[1]) ##1 pin_mode.in_only[1]
    |-> !pd_enable[1])
    else $error("pulldown left on despite disable bit");

  selftest_read_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    addr_valid && !hwrite && rd_idx == `SSD_IDX_DEBUG
    |=> hrdata[`SSD_DBG_SELFTEST] == $past(remote_selftest_in, 2))
    else $error("self-test bit does not follow remote");

  cont_reg_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    port_debug_control[`SSD_DBG_CONT] && return_frame_start |=> return_frame_corrupt)
    else $error("continuous injection missed a frame");

  single_clear_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    port_debug_control[`SSD_DBG_SINGLE] && return_frame_start && !wr_dbg
    |=> return_frame_corrupt ##1 (!port_debug_control[`SSD_DBG_SINGLE] || $past(wr_dbg)))
    else $error("single injection did not fire and clear");

  ro_write_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    wr_pend && (hit(wr_idx, `SSD_IDX_STRAP) || hit(wr_idx, `SSD_IDX_DEBUG))
    |=> !port_debug_control[`SSD_DBG_SELFTEST]
        && ($stable(idx_strap) || $rose(idx_strap.done))
        && ($stable(cfg_strap) || $rose(cfg_strap.done)))
    else $error("write altered read-only state");

  // ----------------------------------------
  // Pulldown pin checks, sampled reset keeps the release edge out
  // ----------------------------------------

  pd_auto_pin1_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    arst_n && !pin_mode.out_mode[1] && !(pin_mode.in_only[1] && pulldown_control[1])
    |=> pd_enable[1])
    else $error("pulldown not enabled on pin one");

  pd_auto_pin2_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    arst_n && !pin_mode.out_mode[2] && !(pin_mode.in_only[2] && pulldown_control[2])
    |=> pd_enable[2])
    else $error("pulldown not enabled on pin two");

  pd_output_off_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    arst_n
    |=> (pd_enable & $past(pin_mode.out_mode)) == 3'h0)
    else $error("pulldown on while pin drives");

  pd_off_pin0_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    arst_n && pin_mode.in_only[0] && pulldown_control[0]
    |=> !pd_enable[0])
    else $error("pulldown left on pin zero");

  pd_off_pin2_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    arst_n && pin_mode.in_only[2] && pulldown_control[2]
    |=> !pd_enable[2])
    else $error("pulldown left on pin two");

  pd_keep_pin0_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    arst_n && !pin_mode.out_mode[0] && pin_mode.in_only[0] && !pulldown_control[0]
    |=> pd_enable[0])
    else $error("pulldown dropped on pin zero");

  pd_keep_pin1_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    arst_n && !pin_mode.out_mode[1] && pin_mode.in_only[1] && !pulldown_control[1]
    |=> pd_enable[1])
    else $error("pulldown dropped on pin one");

  pd_keep_pin2_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    arst_n && !pin_mode.out_mode[2] && pin_mode.in_only[2] && !pulldown_control[2]
    |=> pd_enable[2])
    else $error("pulldown dropped on pin two");

  pulldown_write_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    wr_pull
    |=> pulldown_control == $past(wr_byte))
    else $error("pulldown write did not land");

  // ----------------------------------------
  // Self-test and injection checks
  // ----------------------------------------

  selftest_follow_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    arst_n
    |=> remote_selftest_active == $past(remote_selftest_in))
    else $error("self-test flag lost the remote state");

  cont_write_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    wr_dbg
    |=> port_debug_control[`SSD_DBG_CONT] == $past(wr_byte[`SSD_DBG_CONT]))
    else $error("continuous bit write did not land");

  cont_hold_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !wr_dbg
    |=> $stable(port_debug_control[`SSD_DBG_CONT]))
    else $error("continuous bit changed without write");

  frame_only_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !return_frame_start
    |=> !return_frame_corrupt)
    else $error("corruption without a frame");

  single_set_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    wr_dbg && wr_byte[`SSD_DBG_SINGLE]
    |=> port_debug_control[`SSD_DBG_SINGLE])
    else $error("single request write lost");

  single_stay_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    port_debug_control[`SSD_DBG_SINGLE] && !wr_dbg && !single_done
    |=> port_debug_control[`SSD_DBG_SINGLE])
    else $error("single request cleared without a frame");

  idle_corrupt_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    return_frame_start && !port_debug_control[`SSD_DBG_CONT] && !port_debug_control[`SSD_DBG_SINGLE]
    |=> !return_frame_corrupt)
    else $error("frame corrupted with injection off");

  single_bound_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    port_debug_control[`SSD_DBG_SINGLE] && !port_debug_control[`SSD_DBG_CONT]
      && return_frame_start && !wr_dbg ##1 !wr_dbg ##1 (return_frame_start && !wr_dbg)
    |=> !return_frame_corrupt)
    else $error("single request corrupted a third frame");
endmodule

// file: test/testbench.sv
`timescale 1ns/10ps
`include "ssd_params.svh"
module testbench;
  import ssd_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk, arst_n, hsel, hwrite, hreadyout, hresp;
  logic remote_selftest_in, return_frame_start, return_frame_corrupt, hready;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0] htrans;
  logic [2:0] hsize, idx_lvl, cfg_lvl, pd_enable;
  logic [7:0] pd_reg, dbg;
  ssd_pin_mode_t pin_mode;
  integer seed = 67;
  int n_errors = 0;
  int check_count = 0;
  localparam logic [31:0] A_ST = `SSD_IDX_STRAP * 4;
  localparam logic [31:0] A_PD = `SSD_IDX_PULLDN * 4;
  localparam logic [31:0] A_DBG = `SSD_IDX_DEBUG * 4;
  localparam logic [31:0] A_IE = `SSD_IDX_IEHI * 4;
  localparam logic [31:0] A_NONE = `SSD_IDX_NONE * 4;
  assign hready = hreadyout;

  ssd_regs ssd_regs_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .idx_strap_level(idx_lvl),
    .cfg_strap_level(cfg_lvl), .pin_mode(pin_mode), .pd_enable(pd_enable),
    .remote_selftest_in(remote_selftest_in), .return_frame_start(return_frame_start),
    .return_frame_corrupt(return_frame_corrupt)
  );

  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  function automatic logic [2:0] exp_pd(input ssd_pin_mode_t m, input logic [2:0] d);
    logic [2:0] e;
    e = 3'h0;
    for (int p = 0; p < 3; p++) begin
      // On unless driving, or input-only with its disable bit set
      if (!m.out_mode[p] && !(m.in_only[p] && d[p])) begin
        e[p] = 1'b1;
      end
    end
    return e;
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Bus and frame drivers
  // ----------------------------------------
  task automatic ahb(input int w, input logic [31:0] a, input logic [31:0] d);
    int k;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= (w != 0);
    htrans <= 2'b10;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hready !== 1'b1);
    check("addr wait", 32'h1, 32'(k));
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hready !== 1'b1);
    rdata = hrdata;
    check("data wait", 32'h1, 32'(k));
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic frame(input logic exp);
    return_frame_start <= 1'b1;
    @(posedge sys_clk);
    return_frame_start <= 1'b0;
    @(posedge sys_clk);
    check("corrupt", {31'h0, exp}, {31'h0, return_frame_corrupt});
  endtask

  // Two frames back to back, both may take a single request
  task automatic frame_pair();
    return_frame_start <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    return_frame_start <= 1'b0;
    check("corrupt first", 32'h1, {31'h0, return_frame_corrupt});
    @(posedge sys_clk);
    check("corrupt second", 32'h1, {31'h0, return_frame_corrupt});
  endtask

  // ----------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    #100000;
    n_errors++;
    $display("ERROR watchdog expected done seen hang");
    summarize();
  end

  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pin_mode = '0;
    remote_selftest_in = 1'b0;
    return_frame_start = 1'b0;
    idx_lvl = 3'($random(seed));
    cfg_lvl = 3'($random(seed));
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    ahb(0, A_ST, 0);
    check("done early", 32'h0, rdata & 32'h88);
    ahb(0, A_PD, 0);
    check("pd reset", {24'h0, `SSD_PULLDN_RST}, rdata);
    ahb(0, A_DBG, 0);
    check("dbg reset", {24'h0, `SSD_DEBUG_RST}, rdata);
    ahb(0, A_IE, 0);
    check("ie reset", {24'h0, `SSD_IEHI_RST}, rdata);
    repeat (260) @(posedge sys_clk);
    ahb(1, A_ST, 32'h77);
    ahb(0, A_ST, 0);
    check("strap", {24'h0, 1'b1, idx_lvl, 1'b1, cfg_lvl}, rdata);
    ahb(1, A_NONE, 32'hff);
    ahb(0, A_NONE, 0);
    check("unmapped", 32'h0, rdata);
    ahb(1, A_IE, 32'hff);
    ahb(0, A_IE, 0);
    check("ie mask", {24'h0, `SSD_IEHI_MASK}, rdata);
    pd_reg = 8'h00;
    pin_mode <= 6'h07;
    @(posedge sys_clk);
    @(posedge sys_clk);
    check("pd in only", 32'h7, {29'h0, pd_enable});
    for (int i = 0; i < 16; i++) begin
      if (i % 4 == 1) begin
        pd_reg = 8'($random(seed));
        ahb(1, A_PD, {24'h0, pd_reg});
        ahb(0, A_PD, 0);
        check("pd reg", {24'h0, pd_reg}, rdata);
      end
      pin_mode <= 6'($random(seed));
      @(posedge sys_clk);
      @(posedge sys_clk);
      check("pd", {29'h0, exp_pd(pin_mode, pd_reg[2:0])}, {29'h0, pd_enable});
    end
    ahb(1, A_DBG, 32'hff);
    ahb(0, A_DBG, 0);
    check("dbg ro", 32'hdf, rdata);
    remote_selftest_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ahb(0, A_DBG, 0);
    check("selftest", 32'hff, rdata);
    remote_selftest_in <= 1'b0;
    ahb(1, A_DBG, 32'h0);
    frame(1'b0);
    for (int i = 0; i < 8; i++) begin
      dbg = {6'h0, 2'($random(seed))};
      if (i == 0) begin
        dbg = 8'h02;
      end
      ahb(1, A_DBG, {24'h0, dbg});
      frame(dbg != 8'h0);
      if (dbg[1]) begin
        frame(1'b1);
      end
      ahb(1, A_DBG, 32'h0);
    end
    ahb(1, A_DBG, 32'h01);
    frame(1'b1);
    ahb(0, A_DBG, 0);
    check("single clear", 32'h0, rdata);
    frame(1'b0);
    ahb(1, A_DBG, 32'h01);
    frame_pair();
    frame(1'b0);
    summarize();
  end
endmodule
